// File: logic/fspc_pkg.sv
// constants and types for the serial flash pin control block
// Notes on behaviour
// [R1] output data changes on clock falling edges
// [R2] dual read drives lanes zero and one
// [R3] outputs high impedance while deselected
// [R4] fast program only in single-lane mode
// [R5] write-protect low blocks status writes
// [R6] quad enable ignores write-protect, lane two
// [R7] hold ignores clock, data; floats output
// [R8] hold starts only selected, clock low
// [R9] internal program or erase continues during hold
// [R10] quad program captures four lanes rising
// [R11] quad read drives four lanes falling
// [R12] floating hold reads as deasserted
// [R13] input sampled on rising clock edges
// [R14] hold ends with clock low, resumes
package fspc_pkg;
  // ==========================================
  // lane modes
  typedef enum logic [1:0] {
    FSPC_SINGLE = 2'b00,
    FSPC_DUAL = 2'b01,
    FSPC_QUAD = 2'b10
  } fspc_mode_type;

  localparam int FSPC_LANES = 4;
  localparam logic [3:0] FSPC_OE_NONE = 4'h0;
  localparam logic [3:0] FSPC_OE_SINGLE = 4'h2;
  localparam logic [3:0] FSPC_OE_DUAL = 4'h3;
  localparam logic [3:0] FSPC_OE_QUAD = 4'hf;
  localparam logic [2:0] FSPC_CNT_SINGLE = 3'h1;
  localparam logic [2:0] FSPC_CNT_DUAL = 3'h2;
  localparam logic [2:0] FSPC_CNT_QUAD = 3'h4;
  localparam logic [7:0] FSPC_BYTE_ZERO = 8'h00;
  localparam logic [2:0] FSPC_BIT_ZERO = 3'h0;
  localparam logic [2:0] FSPC_BIT_TOP = 3'h7;

  // ==========================================
  // pad bundle: input, output, enable per lane
  typedef struct packed {
    logic [3:0] din;
    logic [3:0] dout;
    logic [3:0] oe;
  } fspc_pads_type;

  // bits toward command logic
  typedef struct packed {
    logic [7:0] byte_data;
    logic byte_valid;
    logic selected;
    logic hold_active;
  } fspc_rx_type;
endpackage

// File: logic/fspc_sync.sv
// two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module fspc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] rst_val,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb
  begin
    meta_nxt = clk_en ? async_in : meta_r;
    sync_nxt = clk_en ? meta_r : sync_r;
  end

  // reset to zero; rst_val is xored onto sync_out here, so the output reads rst_val from reset
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r ^ rst_val;
endmodule
`default_nettype wire

// File: logic/fspc_top.sv
// pin-level control of the serial flash host interface
`timescale 1ns/1ps
`default_nettype none
module fspc_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic sck_pin,
  input wire logic cs_pin_n,
  input wire logic [3:0] io_din,
  input wire logic hold_pull_up,
  input wire logic fast_program_supply_pin,
  input wire fspc_pkg::fspc_mode_type rd_mode,
  input wire logic qprog_active,
  input wire logic quad_enable_bit,
  input wire logic [7:0] tx_byte,
  input wire logic busy_internal,
  output logic [3:0] io_dout,
  output logic [3:0] io_oe,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic tx_next,
  output logic selected,
  output logic hold_active,
  output logic status_write_ok,
  output logic fast_program_ok,
  output logic busy_out
);
  import fspc_pkg::*;

  // ==========================================
  // synchronisers
  // inverted storage so idle pins (sck, cs, hold high) read inactive from reset
  localparam logic [7:0] FSPC_SYNC_RST = 8'h72;
  logic [7:0] pin_raw;
  logic [7:0] pin_s;
  logic fast_s;
  logic sck_s;
  logic cs_n_s;
  logic [3:0] io_s;
  logic hold_n_s;

  // [R12] pull-up default for hold
  assign pin_raw = {fast_program_supply_pin, sck_pin, cs_pin_n, io_din[3] | hold_pull_up, io_din}
    ^ FSPC_SYNC_RST;

  fspc_sync #(
    .WIDTH(8)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .async_in(pin_raw),
    .rst_val(FSPC_SYNC_RST),
    .sync_out(pin_s)
  );

  assign fast_s = pin_s[7];
  assign sck_s = pin_s[6];
  assign cs_n_s = pin_s[5];
  assign hold_n_s = pin_s[4];
  assign io_s = pin_s[3:0];

  function automatic logic [2:0] lane_count(input fspc_mode_type m);
    unique case (m)
      FSPC_SINGLE: lane_count = FSPC_CNT_SINGLE;
      FSPC_DUAL: lane_count = FSPC_CNT_DUAL;
      FSPC_QUAD: lane_count = FSPC_CNT_QUAD;
      default: lane_count = FSPC_CNT_SINGLE;
    endcase
  endfunction

  // ==========================================
  // state
  logic sck_d_r;
  logic sck_d_nxt;
  logic hold_r;
  logic hold_nxt;
  logic [7:0] sh_in_r;
  logic [7:0] sh_in_nxt;
  logic [2:0] in_cnt_r;
  logic [2:0] in_cnt_nxt;
  logic [7:0] sh_out_r;
  logic [7:0] sh_out_nxt;
  logic [2:0] out_cnt_r;
  logic [2:0] out_cnt_nxt;
  logic [3:0] dout_r;
  logic [3:0] dout_nxt;
  logic [3:0] oe_r;
  logic [3:0] oe_nxt;
  logic [7:0] rx_r;
  logic [7:0] rx_nxt;
  logic rx_v_r;
  logic rx_v_nxt;
  logic txn_r;
  logic txn_nxt;
  logic sel_r;
  logic sel_nxt;
  logic swok_r;
  logic swok_nxt;
  logic fpok_r;
  logic fpok_nxt;
  logic busy_r;
  logic busy_nxt;
  logic rise;
  logic fall;
  logic sel;
  logic wp_n;
  logic [2:0] in_w;
  logic [2:0] out_w;
  logic [3:0] oe_mode;
  logic [7:0] tx_src;

  assign rise = sck_s & ~sck_d_r;
  assign fall = ~sck_s & sck_d_r;
  assign sel = ~cs_n_s;
  assign wp_n = io_s[2];
  assign out_w = lane_count(rd_mode);
  // [R10] quad program widens capture
  assign in_w = qprog_active ? FSPC_CNT_QUAD : FSPC_CNT_SINGLE;
  // new byte taken only at the start of each byte
  assign tx_src = (out_cnt_r == FSPC_BIT_ZERO) ? tx_byte : sh_out_r;

  always_comb
  begin
    unique case (rd_mode)
      FSPC_SINGLE: oe_mode = FSPC_OE_SINGLE;
      FSPC_DUAL: oe_mode = FSPC_OE_DUAL;
      FSPC_QUAD: oe_mode = FSPC_OE_QUAD;
      default: oe_mode = FSPC_OE_SINGLE;
    endcase
  end

  // ==========================================
  // next state
  always_comb
  begin
    sck_d_nxt = sck_s;
    hold_nxt = hold_r;
    sh_in_nxt = sh_in_r;
    in_cnt_nxt = in_cnt_r;
    sh_out_nxt = sh_out_r;
    out_cnt_nxt = out_cnt_r;
    dout_nxt = dout_r;
    oe_nxt = oe_r;
    rx_nxt = rx_r;
    rx_v_nxt = 1'b0;
    txn_nxt = 1'b0;
    sel_nxt = sel;
    // [R9] internal busy passes through hold
    busy_nxt = busy_internal;
    // [R5] [R6] write-protect gate
    swok_nxt = quad_enable_bit | wp_n;
    // [R4] single-lane only fast program
    fpok_nxt = fast_s & (rd_mode == FSPC_SINGLE) & ~qprog_active
      & ~quad_enable_bit;
    if (!sel)
    begin
      // [R3] float outputs deselected
      hold_nxt = 1'b0;
      oe_nxt = FSPC_OE_NONE;
      in_cnt_nxt = FSPC_BIT_ZERO;
      out_cnt_nxt = FSPC_BIT_ZERO;
    end
    else if (!hold_r)
    begin
      // [R8] hold begins selected, clock low; quad lane three is data, not hold
      if (!hold_n_s && !sck_s && !qprog_active && rd_mode != FSPC_QUAD && !quad_enable_bit)
      begin
        hold_nxt = 1'b1;
        oe_nxt = FSPC_OE_NONE;
      end
      else
      begin
        // [R13] capture on rising edge
        if (rise)
        begin
          if (in_w == FSPC_CNT_QUAD)
            sh_in_nxt = {sh_in_r[3:0], io_s};
          else
            sh_in_nxt = {sh_in_r[6:0], io_s[0]};
          in_cnt_nxt = in_cnt_r + in_w;
          if (in_cnt_nxt == FSPC_BIT_ZERO)
          begin
            rx_nxt = sh_in_nxt;
            rx_v_nxt = 1'b1;
          end
        end
        // [R1] shift out on falling edge
        if (fall)
        begin
          txn_nxt = (out_cnt_r == FSPC_BIT_ZERO);
          // [R2] [R11] lane enables per read mode
          oe_nxt = oe_mode;
          unique case (rd_mode)
            FSPC_DUAL: dout_nxt = {2'b00, tx_src[7:6]};
            FSPC_QUAD: dout_nxt = tx_src[7:4];
            default: dout_nxt = {2'b00, tx_src[7], 1'b0};
          endcase
          sh_out_nxt = tx_src << out_w;
          out_cnt_nxt = out_cnt_r + out_w;
        end
      end
    end
    else
    begin
      // [R7] clock and data ignored while held
      oe_nxt = FSPC_OE_NONE;
      // [R14] release with clock low, counters kept
      if (hold_n_s && !sck_s)
        hold_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_d_r <= 1'b1;
      hold_r <= 1'b0;
      sh_in_r <= FSPC_BYTE_ZERO;
      in_cnt_r <= FSPC_BIT_ZERO;
      sh_out_r <= FSPC_BYTE_ZERO;
      out_cnt_r <= FSPC_BIT_ZERO;
      dout_r <= FSPC_OE_NONE;
      oe_r <= FSPC_OE_NONE;
      rx_r <= FSPC_BYTE_ZERO;
      rx_v_r <= 1'b0;
      txn_r <= 1'b0;
      sel_r <= 1'b0;
      swok_r <= 1'b0;
      fpok_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else if (clk_en)
    begin
      sck_d_r <= sck_d_nxt;
      hold_r <= hold_nxt;
      sh_in_r <= sh_in_nxt;
      in_cnt_r <= in_cnt_nxt;
      sh_out_r <= sh_out_nxt;
      out_cnt_r <= out_cnt_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      rx_r <= rx_nxt;
      rx_v_r <= rx_v_nxt;
      txn_r <= txn_nxt;
      sel_r <= sel_nxt;
      swok_r <= swok_nxt;
      fpok_r <= fpok_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign io_dout = dout_r;
  assign io_oe = oe_r;
  assign rx_byte = rx_r;
  assign rx_valid = rx_v_r;
  assign tx_next = txn_r;
  assign selected = sel_r;
  assign hold_active = hold_r;
  assign status_write_ok = swok_r;
  assign fast_program_ok = fpok_r;
  assign busy_out = busy_r;
endmodule
`default_nettype wire

// File: bench/fspc_properties.sv
// concurrent checks on the pin control block ports
`timescale 1ns/1ps
`default_nettype none
module fspc_properties
  import fspc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic sck_pin,
  input wire logic cs_pin_n,
  input wire logic [3:0] io_din,
  input wire fspc_pkg::fspc_mode_type rd_mode,
  input wire logic qprog_active,
  input wire logic quad_enable_bit,
  input wire logic busy_internal,
  input wire logic [3:0] io_dout,
  input wire logic [3:0] io_oe,
  input wire logic rx_valid,
  input wire logic tx_next,
  input wire logic hold_active,
  input wire logic status_write_ok,
  input wire logic fast_program_ok,
  input wire logic busy_out
);
  default clocking @(posedge sys_clk); endclocking
  // latency counts only hold while the enable runs
  default disable iff (!rst_n || !clk_en);
  // ==========================================
  // pin level checks
  desel_float_a: assert property (cs_pin_n [*6] |-> io_oe == FSPC_OE_NONE)
    else $error("lanes driven while deselected");
  hold_float_a: assert property (hold_active [*2] |-> io_oe == FSPC_OE_NONE)
    else $error("lanes driven while held");
  // mode changes only while deselected, so a steady mode is the cause
  lane_mode_a: assert property (io_oe != FSPC_OE_NONE && $stable(rd_mode) |->
    io_oe == (rd_mode == FSPC_QUAD ? FSPC_OE_QUAD :
    rd_mode == FSPC_DUAL ? FSPC_OE_DUAL : FSPC_OE_SINGLE))
    else $error("output lanes do not match mode");
  dout_steady_a: assert property ((sck_pin && !cs_pin_n) [*8] |-> $stable(io_dout))
    else $error("output data moved without falling clock");
  wp_block_a: assert property ((!quad_enable_bit && !io_din[2]) [*4] |-> !status_write_ok)
    else $error("status write allowed while protected");
  qe_ignore_wp_a: assert property (quad_enable_bit [*4] |-> status_write_ok)
    else $error("protect pin honoured in quad");
  fast_gate_a: assert property ((qprog_active || quad_enable_bit || rd_mode == FSPC_DUAL ||
    rd_mode == FSPC_QUAD) [*4] |-> !fast_program_ok)
    else $error("fast program outside single lane");
  busy_pass_a: assert property (busy_internal [*4] |-> busy_out)
    else $error("busy lost");
  rx_pulse_a: assert property (rx_valid |=> !rx_valid)
    else $error("receive pulse too long");
  cover property (rx_valid);
  cover property (hold_active);
  cover property (io_oe == FSPC_OE_QUAD);
endmodule
bind fspc_top fspc_properties fspc_properties_i (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .clk_en(clk_en),
  .sck_pin(sck_pin),
  .cs_pin_n(cs_pin_n),
  .io_din(io_din),
  .rd_mode(rd_mode),
  .qprog_active(qprog_active),
  .quad_enable_bit(quad_enable_bit),
  .busy_internal(busy_internal),
  .io_dout(io_dout),
  .io_oe(io_oe),
  .rx_valid(rx_valid),
  .tx_next(tx_next),
  .hold_active(hold_active),
  .status_write_ok(status_write_ok),
  .fast_program_ok(fast_program_ok),
  .busy_out(busy_out)
);
`default_nettype wire

// File: bench/fspc_host.sv
// behavioural serial host driving the pin control block
`timescale 1ns/1ps
`default_nettype none
module fspc_host (
  input wire logic clk,
  input wire logic [3:0] q,
  output var logic sck,
  output var logic cs_n,
  output var logic [3:0] d
);
  initial
  begin
    sck = 1'b1;
    cs_n = 1'b1;
    d = 4'hf;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // released lanes invert, never keep stale data
  task automatic sel(input logic off);
    cs_n = off;
    if (off) d = ~d;
    w(8);
  endtask
  // protect lane level, then let it settle
  task automatic protect_lane(input logic v);
    d[2] = v;
    w(8);
  endtask
  // hold moves only with clock low
  task automatic hold(input logic on);
    sck = 1'b0;
    w(1);
    d[3] = !on;
    w(8);
  endtask
  // data set at fall, read back at rise
  task automatic tick(input logic [3:0] v, output logic [3:0] s);
    sck = 1'b0;
    d = v;
    w(8);
    sck = 1'b1;
    s = q;
    w(8);
  endtask
endmodule
`default_nettype wire

// File: bench/flash_serial_pin_control_test.sv
// self-checking bench for the serial flash pin control block
`timescale 1ns/1ps
`default_nettype none
module flash_serial_pin_control_test;
  import fspc_pkg::*;
  logic sys_clk, rst_n, clk_en, sck_pin, cs_pin_n, hold_pull_up;
  logic fast_program_supply_pin, qprog_active, quad_enable_bit, busy_internal;
  logic [3:0] io_din, io_dout, io_oe, s;
  logic [7:0] tx_byte, rx_byte, a, r;
  logic rx_valid, tx_next, selected, hold_active, status_write_ok, fast_program_ok, busy_out;
  fspc_mode_type rd_mode;
  int miscompares = 0, check_count = 0, seed = 11, tx_loads = 0;
  logic [7:0] q[$];
  fspc_top fspc_top_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .sck_pin(sck_pin),
    .cs_pin_n(cs_pin_n),
    .io_din(io_din),
    .hold_pull_up(hold_pull_up),
    .fast_program_supply_pin(fast_program_supply_pin),
    .rd_mode(rd_mode),
    .qprog_active(qprog_active),
    .quad_enable_bit(quad_enable_bit),
    .tx_byte(tx_byte),
    .busy_internal(busy_internal),
    .io_dout(io_dout),
    .io_oe(io_oe),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid),
    .tx_next(tx_next),
    .selected(selected),
    .hold_active(hold_active),
    .status_write_ok(status_write_ok),
    .fast_program_ok(fast_program_ok),
    .busy_out(busy_out)
  );
  fspc_host fspc_host_i (.clk(sys_clk), .q(io_dout), .sck(sck_pin), .cs_n(cs_pin_n), .d(io_din));
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk(input string n, input logic [7:0] v, e);
    check_count++;
    if (v !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // w lanes per clock; r gathers what the device sends
  task automatic xfer(input int w, lo, hi, input logic [7:0] v);
    for (int i = lo; i < hi; i += w)
    begin
      // hold and protect lanes idle high outside quad
      fspc_host_i.tick(w == 4 ? v[7-i -: 4] : {3'h7, v[7-i]}, s);
      r = w == 1 ? {r[6:0], s[1]} : w == 2 ? {r[5:0], s[1:0]} : {r[3:0], s};
    end
  endtask
  // ==========================================
  // monitor: oldest note against each received byte
  always @(posedge sys_clk)
    if (rx_valid === 1'b1)
      chk("rx_byte", rx_byte, q.size() ? q.pop_front() : 8'hxx);
  // one load strobe per byte begun
  always @(posedge sys_clk)
    if (tx_next === 1'b1)
      tx_loads++;
  initial
  begin
    #200000;
    miscompares++;
    results;
  end
  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    hold_pull_up = 1'b1;
    fast_program_supply_pin = 1'b0;
    qprog_active = 1'b0;
    quad_enable_bit = 1'b0;
    busy_internal = 1'b0;
    tx_byte = 8'h00;
    rd_mode = FSPC_SINGLE;
    repeat (16) @(posedge sys_clk);
    #2 rst_n = 1;
    fspc_host_i.w(4);
    // partial bytes of dual and quad reads are dropped
    for (int m = 0; m < 3; m++)
    begin
      a = $random(seed);
      tx_byte = $random(seed);
      rd_mode = fspc_mode_type'(m);
      fspc_host_i.sel(0);
      chk("selected", selected, 1);
      if (m == 0) q.push_back(a);
      xfer(1 << m, 0, 8, a);
      chk("tx_byte", r, tx_byte);
      chk("lane_oe", io_oe, m == 0 ? FSPC_OE_SINGLE :
        m == 1 ? FSPC_OE_DUAL : FSPC_OE_QUAD);
      fspc_host_i.sel(1);
      chk("io_oe", {selected, io_oe}, 0);
    end
    $display("reads done");
    qprog_active = 1;
    hold_pull_up = 0;
    rd_mode = FSPC_SINGLE;
    a = $random(seed);
    q.push_back(a);
    fspc_host_i.sel(0);
    xfer(4, 0, 8, a);
    fspc_host_i.sel(1);
    qprog_active = 0;
    $display("quad program done");
    a = $random(seed);
    q.push_back(a);
    fspc_host_i.sel(0);
    xfer(1, 0, 4, a);
    hold_pull_up = 1;
    fspc_host_i.hold(1);
    chk("hold_pulled", hold_active, 0);
    hold_pull_up = 0;
    busy_internal = 1;
    fspc_host_i.w(8);
    chk("held", {hold_active, io_oe}, 8'h10);
    repeat (3) fspc_host_i.tick(4'h0, s);
    fspc_host_i.hold(1);
    chk("busy_out", busy_out, 1);
    fspc_host_i.hold(0);
    chk("released", hold_active, 0);
    busy_internal = 0;
    hold_pull_up = 1;
    xfer(1, 4, 8, a);
    chk("tx_resumed", r, tx_byte);
    fspc_host_i.sel(1);
    $display("hold done");
    // host applies the program supply only for this table
    fast_program_supply_pin = 1;
    for (int k = 0; k < 16; k++)
    begin
      {quad_enable_bit, qprog_active} = {k[3], k[1]};
      rd_mode = fspc_mode_type'(k[0]);
      fspc_host_i.protect_lane(k[2]);
      chk("status_write_ok", status_write_ok, k[3] | k[2]);
      chk("fast_program_ok", fast_program_ok, !k[3] && !k[1] && !k[0]);
    end
    fast_program_supply_pin = 0;
    // state must freeze while the enable is low
    clk_en = 1'b0;
    quad_enable_bit = 1'b0;
    fspc_host_i.protect_lane(1'b0);
    chk("frozen", status_write_ok, 1);
    clk_en = 1'b1;
    fspc_host_i.w(8);
    chk("unfrozen", status_write_ok, 0);
    chk("tx_next", tx_loads, 5);
    chk("notes left", q.size(), 0);
    $display("pin gating done");
    results;
  end
endmodule
`default_nettype wire
